// [design/ais_defines.vh]
// Constants for the converter input select and scan block.
// Assumes a 16-bit register port and one system clock domain.
//
// Overview of operation
// - Mux B negative bit set routes analog input 1, clear routes negative ref.
// - Mux B positive codes 0 through 23 pick analog pins 0 through 23.
// - Codes 24..27 pick half bandgap, full bandgap, core supply, sixth bandgap.
// - Code 31 connects nothing; all inputs float for the charge time unit.
// - Mux A negative bit behaves exactly like the mux B negative bit.
// - Mux A positive field in bits 4..0 decodes like the mux B field.
// - Bits 14..13 and 6..5 of the input select register read zero.
// - Small package variant offers no analog inputs 16 through 23.
// - Bandgap config bits 2,1,0 enable sixth, half and full references.
// - Each low scan mask bit adds the channel of the same index.
// - High scan mask bits 7..0 add channels 16..23; absent on small package.
// - High scan bits 8..11 add half, full, core supply, sixth reference.
// - Conversion clock period is cycle time times divider value plus one.
// - All implemented register bits are zero after reset.
// - Scan mask acts only with scan enable set; it overrides mux A positive.
// - Alternate mode samples A first, then B and A in turn; else always A.
`ifndef AIS_DEFINES_VH
`define AIS_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets (word index on the register port)
// ----------------------------------------------------------------------
`define AIS_OFS_INPUT_SELECT 3'h0
`define AIS_OFS_BANDGAP_CFG 3'h1
`define AIS_OFS_SCAN_LOW 3'h2
`define AIS_OFS_SCAN_HIGH 3'h3
`define AIS_OFS_SEQ_CTRL 3'h4
`define AIS_OFS_CLK_DIV 3'h5
`define AIS_OFS_STATUS 3'h6

// ----------------------------------------------------------------------
// Writable masks and reset values
// ----------------------------------------------------------------------
`define AIS_MASK_INPUT_SELECT 16'h9F9F
`define AIS_MASK_BANDGAP_CFG 16'h0007
`define AIS_MASK_SCAN_LOW 16'hFFFF
`define AIS_MASK_SCAN_HIGH 16'h0FFF
`define AIS_MASK_SCAN_HIGH_SMALL 16'h0F00
`define AIS_MASK_SEQ_CTRL 16'h0401
`define AIS_MASK_CLK_DIV 16'h00FF
`define AIS_RESET_VALUE 16'h0000

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define AIS_BIT_NEG_SEL_B 15
`define AIS_POS_SEL_B_MSB 12
`define AIS_POS_SEL_B_LSB 8
`define AIS_BIT_NEG_SEL_A 7
`define AIS_POS_SEL_A_MSB 4
`define AIS_POS_SEL_A_LSB 0
`define AIS_BIT_SIXTH_REF_ON 2
`define AIS_BIT_HALF_REF_ON 1
`define AIS_BIT_FULL_REF_ON 0
`define AIS_BIT_SCAN_ENABLE 10
`define AIS_BIT_ALT_SAMPLE 0

// ----------------------------------------------------------------------
// Positive select codes
// ----------------------------------------------------------------------
`define AIS_CODE_LAST_PIN 5'h17
`define AIS_CODE_LAST_SMALL_PIN 5'h0F
`define AIS_CODE_HALF_REF 5'h18
`define AIS_CODE_FULL_REF 5'h19
`define AIS_CODE_CORE 5'h1A
`define AIS_CODE_SIXTH_REF 5'h1B
`define AIS_CODE_NONE 5'h1F
`define AIS_SCAN_SLOTS 28
`define AIS_PIN_COUNT 24

`endif

// [design/ais_input_select.v]
// Converter input select, bandgap tap enables, scan and alternate sampling.
// Assumes a synchronous register port and a sample request pulse from the
// converter sequencer, all on sys_clk.
`timescale 1ns/1ns
`default_nettype none
`include "ais_defines.vh"

module ais_input_select #(
    parameter SMALL_PACKAGE = 0
) (
    input wire sys_clk,
    input wire rst_n,
    input wire ce,
    input wire [2:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    input wire sample_req,
    output reg [23:0] ain_pos_sel,
    output reg half_ref_sel,
    output reg full_ref_sel,
    output reg core_supply_sel,
    output reg sixth_ref_sel,
    output reg neg_ain1_sel,
    output reg neg_vref_sel,
    output reg inputs_floating,
    output reg sixth_ref_on,
    output reg half_ref_on,
    output reg full_ref_on,
    output reg conv_clk_tick
);

// ----------------------------------------------------------------------
// Sequence states
// ----------------------------------------------------------------------
localparam ST_MUX_A = 1'b0;
localparam ST_MUX_B = 1'b1;

// ----------------------------------------------------------------------
// Register file
// ----------------------------------------------------------------------
reg [15:0] input_select_r;
reg [15:0] bandgap_cfg_r;
reg [15:0] scan_low_r;
reg [15:0] scan_high_r;
reg [15:0] seq_ctrl_r;
reg [15:0] clk_div_r;
reg seq_state_r;
reg [4:0] scan_idx_r;
reg [4:0] cur_code_r;
reg cur_neg_r;
reg [7:0] div_cnt_r;

wire [15:0] scan_high_mask;
wire scan_enable_bit;
wire alternate_sample;
wire [27:0] scan_pick;
wire neg_sel_a;
wire neg_sel_b;
wire [4:0] pos_sel_a;
wire [4:0] pos_sel_b;

// Small package loses the upper eight pins in the scan mask
assign scan_high_mask = (SMALL_PACKAGE != 0) ?
    `AIS_MASK_SCAN_HIGH_SMALL : `AIS_MASK_SCAN_HIGH;
assign scan_enable_bit = seq_ctrl_r[`AIS_BIT_SCAN_ENABLE];
assign alternate_sample = seq_ctrl_r[`AIS_BIT_ALT_SAMPLE];
assign scan_pick = {scan_high_r[11:0], scan_low_r};
assign neg_sel_a = input_select_r[`AIS_BIT_NEG_SEL_A];
assign neg_sel_b = input_select_r[`AIS_BIT_NEG_SEL_B];
assign pos_sel_a = input_select_r[`AIS_POS_SEL_A_MSB:`AIS_POS_SEL_A_LSB];
assign pos_sel_b = input_select_r[`AIS_POS_SEL_B_MSB:`AIS_POS_SEL_B_LSB];

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        input_select_r <= `AIS_RESET_VALUE;
        bandgap_cfg_r <= `AIS_RESET_VALUE;
        scan_low_r <= `AIS_RESET_VALUE;
        scan_high_r <= `AIS_RESET_VALUE;
        seq_ctrl_r <= `AIS_RESET_VALUE;
        clk_div_r <= `AIS_RESET_VALUE;
    end else if (ce && reg_wr) begin
        // Unused bit pairs are masked off so they always read zero
        if (reg_addr == `AIS_OFS_INPUT_SELECT) begin
            input_select_r <= reg_wdata & `AIS_MASK_INPUT_SELECT;
        end else if (reg_addr == `AIS_OFS_BANDGAP_CFG) begin
            bandgap_cfg_r <= reg_wdata & `AIS_MASK_BANDGAP_CFG;
        end else if (reg_addr == `AIS_OFS_SCAN_LOW) begin
            scan_low_r <= reg_wdata & `AIS_MASK_SCAN_LOW;
        end else if (reg_addr == `AIS_OFS_SCAN_HIGH) begin
            scan_high_r <= reg_wdata & scan_high_mask;
        end else if (reg_addr == `AIS_OFS_SEQ_CTRL) begin
            seq_ctrl_r <= reg_wdata & `AIS_MASK_SEQ_CTRL;
        end else if (reg_addr == `AIS_OFS_CLK_DIV) begin
            clk_div_r <= reg_wdata & `AIS_MASK_CLK_DIV;
        end
    end
end

// ----------------------------------------------------------------------
// Register read, data one cycle after the strobe
// ----------------------------------------------------------------------
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        reg_rdata <= 16'h0000;
    end else if (ce) begin
        if (!reg_rd) begin
            reg_rdata <= 16'h0000;
        end else if (reg_addr == `AIS_OFS_INPUT_SELECT) begin
            reg_rdata <= input_select_r;
        end else if (reg_addr == `AIS_OFS_BANDGAP_CFG) begin
            reg_rdata <= bandgap_cfg_r;
        end else if (reg_addr == `AIS_OFS_SCAN_LOW) begin
            reg_rdata <= scan_low_r;
        end else if (reg_addr == `AIS_OFS_SCAN_HIGH) begin
            reg_rdata <= scan_high_r;
        end else if (reg_addr == `AIS_OFS_SEQ_CTRL) begin
            reg_rdata <= seq_ctrl_r;
        end else if (reg_addr == `AIS_OFS_CLK_DIV) begin
            reg_rdata <= clk_div_r;
        end else if (reg_addr == `AIS_OFS_STATUS) begin
            reg_rdata <= {8'h00, seq_state_r, cur_neg_r, 1'b0, cur_code_r};
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
end

// ----------------------------------------------------------------------
// Scan search: first selected slot at or after the scan index
// ----------------------------------------------------------------------
reg scan_found;
reg [4:0] scan_hit;
integer i;
integer slot;

always @* begin
    scan_found = 1'b0;
    scan_hit = 5'h00;
    slot = 0;
    // Wrapping search keeps order ascending from the index
    for (i = 0; i < `AIS_SCAN_SLOTS; i = i + 1) begin
        slot = scan_idx_r + i;
        if (slot >= `AIS_SCAN_SLOTS) begin
            slot = slot - `AIS_SCAN_SLOTS;
        end
        if (!scan_found && scan_pick[slot]) begin
            scan_found = 1'b1;
            scan_hit = slot[4:0];
        end
    end
end

// ----------------------------------------------------------------------
// Choice of settings for the sample being started
// ----------------------------------------------------------------------
reg use_b;
reg [4:0] pick_code;
reg pick_neg;
reg seq_state_nxt;
reg [4:0] scan_idx_nxt;

always @* begin
    use_b = alternate_sample && (seq_state_r == ST_MUX_B);
    seq_state_nxt = seq_state_r;
    scan_idx_nxt = scan_idx_r;
    if (use_b) begin
        pick_code = pos_sel_b;
        pick_neg = neg_sel_b;
    end else begin
        // Empty mask falls back to the plain mux A field
        if (scan_enable_bit && scan_found) begin
            pick_code = scan_hit;
        end else begin
            pick_code = pos_sel_a;
        end
        pick_neg = neg_sel_a;
    end
    case (seq_state_r)
        ST_MUX_A: begin
            if (alternate_sample) begin
                seq_state_nxt = ST_MUX_B;
            end
            if (scan_enable_bit && scan_found) begin
                if (scan_hit == `AIS_SCAN_SLOTS - 1) begin
                    scan_idx_nxt = 5'h00;
                end else begin
                    scan_idx_nxt = scan_hit + 5'h01;
                end
            end
        end
        default: begin
            seq_state_nxt = ST_MUX_A;
        end
    endcase
end

// Any control write restarts the sequence at the first mux A sample
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        seq_state_r <= ST_MUX_A;
        scan_idx_r <= 5'h00;
        cur_code_r <= 5'h00;
        cur_neg_r <= 1'b0;
    end else if (ce) begin
        if (reg_wr && reg_addr == `AIS_OFS_SEQ_CTRL) begin
            seq_state_r <= ST_MUX_A;
            scan_idx_r <= 5'h00;
        end else if (sample_req) begin
            seq_state_r <= seq_state_nxt;
            scan_idx_r <= scan_idx_nxt;
            cur_code_r <= pick_code;
            cur_neg_r <= pick_neg;
        end
    end
end

// ----------------------------------------------------------------------
// Decode of the held code onto the analog switches
// ----------------------------------------------------------------------
wire code_is_pin;
assign code_is_pin = (SMALL_PACKAGE != 0) ?
    (cur_code_r <= `AIS_CODE_LAST_SMALL_PIN) :
    (cur_code_r <= `AIS_CODE_LAST_PIN);

genvar g;
generate
    for (g = 0; g < `AIS_PIN_COUNT; g = g + 1) begin : pin_dec
        always @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                ain_pos_sel[g] <= 1'b0;
            end else if (ce) begin
                ain_pos_sel[g] <= code_is_pin &&
                    ({27'h0000000, cur_code_r} == g);
            end
        end
    end
endgenerate

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        half_ref_sel <= 1'b0;
        full_ref_sel <= 1'b0;
        core_supply_sel <= 1'b0;
        sixth_ref_sel <= 1'b0;
        neg_ain1_sel <= 1'b0;
        neg_vref_sel <= 1'b0;
        inputs_floating <= 1'b0;
    end else if (ce) begin
        half_ref_sel <= (cur_code_r == `AIS_CODE_HALF_REF);
        full_ref_sel <= (cur_code_r == `AIS_CODE_FULL_REF);
        core_supply_sel <= (cur_code_r == `AIS_CODE_CORE);
        sixth_ref_sel <= (cur_code_r == `AIS_CODE_SIXTH_REF);
        // The no-channel code drives nothing; codes 28 to 30 still drive the negative input
        if (cur_code_r == `AIS_CODE_NONE) begin
            neg_ain1_sel <= 1'b0;
            neg_vref_sel <= 1'b0;
            inputs_floating <= 1'b1;
        end else begin
            neg_ain1_sel <= cur_neg_r;
            neg_vref_sel <= !cur_neg_r;
            inputs_floating <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------------
// Bandgap tap enables
// ----------------------------------------------------------------------
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        sixth_ref_on <= 1'b0;
        half_ref_on <= 1'b0;
        full_ref_on <= 1'b0;
    end else if (ce) begin
        sixth_ref_on <= bandgap_cfg_r[`AIS_BIT_SIXTH_REF_ON];
        half_ref_on <= bandgap_cfg_r[`AIS_BIT_HALF_REF_ON];
        full_ref_on <= bandgap_cfg_r[`AIS_BIT_FULL_REF_ON];
    end
end

// ----------------------------------------------------------------------
// Conversion clock, one tick per divider value plus one cycles
// ----------------------------------------------------------------------
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        div_cnt_r <= 8'h00;
        conv_clk_tick <= 1'b0;
    end else if (ce) begin
        // A divider below the current count forces a wrap on the next cycle
        if (div_cnt_r >= clk_div_r[7:0]) begin
            div_cnt_r <= 8'h00;
            conv_clk_tick <= 1'b1;
        end else begin
            div_cnt_r <= div_cnt_r + 8'h01;
            conv_clk_tick <= 1'b0;
        end
    end
end

endmodule
`default_nettype wire

// [bench/ais_input_select_monitor.sv]
// Assertion checker for the converter input select block.
// Assumes it sees only the block ports, one clock, ce held high in use.
`timescale 1ns/1ns
`default_nettype none
`include "ais_defines.vh"
module ais_input_select_monitor #(
    parameter SMALL_PACKAGE = 0
) (
    input wire sys_clk,
    input wire rst_n,
    input wire ce,
    input wire [2:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_rdata,
    input wire sample_req,
    input wire [23:0] ain_pos_sel,
    input wire half_ref_sel,
    input wire full_ref_sel,
    input wire core_supply_sel,
    input wire sixth_ref_sel,
    input wire neg_ain1_sel,
    input wire neg_vref_sel,
    input wire inputs_floating,
    input wire sixth_ref_on,
    input wire half_ref_on,
    input wire full_ref_on,
    input wire conv_clk_tick
);
    // ------------------------------------------------------------------
    // Register mirrors
    // ------------------------------------------------------------------
    reg [15:0] sel_r;
    reg [15:0] seq_r;
    reg [7:0] div_r;
    reg [8:0] gap_r;
    reg [8:0] quiet_r;
    wire wr_en = ce && reg_wr;
    wire [4:0] code_a = sel_r[4:0];
    wire pin_ok = code_a <= `AIS_CODE_LAST_PIN &&
        !(SMALL_PACKAGE != 0 && code_a > `AIS_CODE_LAST_SMALL_PIN);
    wire [23:0] pin_exp = pin_ok ? 24'h000001 << code_a : 24'h000000;

    // Period only judged once the divider has been quiet a long while
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_r <= 16'h0000;
            seq_r <= 16'h0000;
            div_r <= 8'h00;
            gap_r <= 9'h000;
            quiet_r <= 9'h000;
        end else if (ce) begin
            if (wr_en && reg_addr == `AIS_OFS_INPUT_SELECT)
                sel_r <= reg_wdata & `AIS_MASK_INPUT_SELECT;
            if (wr_en && reg_addr == `AIS_OFS_SEQ_CTRL)
                seq_r <= reg_wdata & `AIS_MASK_SEQ_CTRL;
            if (wr_en && reg_addr == `AIS_OFS_CLK_DIV)
                div_r <= reg_wdata[7:0];
            gap_r <= conv_clk_tick ? 9'h000 : gap_r + 9'h001;
            if (wr_en && reg_addr == `AIS_OFS_CLK_DIV)
                quiet_r <= 9'h000;
            else if (quiet_r != 9'h1FF)
                quiet_r <= quiet_r + 9'h001;
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_plain_a;
        ce && sample_req && !reg_wr && seq_r == 16'h0000;
    endsequence

    a_one_source: assert property ($onehot0({ain_pos_sel, half_ref_sel,
        full_ref_sel, core_supply_sel, sixth_ref_sel, inputs_floating}))
        else $error("more than one positive source");
    a_float_alone: assert property (inputs_floating |-> ain_pos_sel == 24'h0
        && !half_ref_sel && !full_ref_sel && !core_supply_sel
        && !sixth_ref_sel && !neg_ain1_sel && !neg_vref_sel)
        else $error("floating with a source connected");
    a_neg_one: assert property ($past(rst_n, 2) && !inputs_floating |->
        neg_ain1_sel ^ neg_vref_sel)
        else $error("negative input not exactly one");
    a_small_pins: assert property (SMALL_PACKAGE != 0 |-> ain_pos_sel[23:16] == 8'h00)
        else $error("absent pin connected");
    a_neg_a: assert property (s_plain_a |-> ##2 neg_ain1_sel ==
        ($past(sel_r[7], 2) && $past(code_a, 2) != `AIS_CODE_NONE))
        else $error("mux A negative input wrong");
    a_pos_a: assert property (s_plain_a |-> ##2 ain_pos_sel == $past(pin_exp, 2))
        else $error("mux A positive pin wrong");
    a_tap_follow: assert property (wr_en && reg_addr == 3'h1 |-> ##2
        {sixth_ref_on, half_ref_on, full_ref_on} == $past(reg_wdata[2:0], 2))
        else $error("tap enables wrong");
    a_sel_gaps: assert property (ce && reg_rd && reg_addr == 3'h0 |=>
        (reg_rdata & 16'h6060) == 16'h0000) else $error("unused bits set");
    a_high_gaps: assert property (ce && reg_rd && reg_addr == 3'h3 |=>
        reg_rdata[15:12] == 4'h0 && (SMALL_PACKAGE == 0 || reg_rdata[7:0] == 8'h00))
        else $error("scan high unimplemented bits set");
    a_tick_gap: assert property (conv_clk_tick && quiet_r == 9'h1FF |->
        gap_r == {1'b0, div_r}) else $error("tick period wrong");
endmodule

bind ais_input_select ais_input_select_monitor #(
    .SMALL_PACKAGE(SMALL_PACKAGE)) i_mon (
    .sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sample_req(sample_req),
    .ain_pos_sel(ain_pos_sel), .half_ref_sel(half_ref_sel),
    .full_ref_sel(full_ref_sel), .core_supply_sel(core_supply_sel),
    .sixth_ref_sel(sixth_ref_sel), .neg_ain1_sel(neg_ain1_sel),
    .neg_vref_sel(neg_vref_sel), .inputs_floating(inputs_floating),
    .sixth_ref_on(sixth_ref_on), .half_ref_on(half_ref_on),
    .full_ref_on(full_ref_on), .conv_clk_tick(conv_clk_tick));
`default_nettype wire

// [bench/ais_input_select_tb.sv]
// Self-checking bench for the converter input select block.
// Assumes the checker is bound in; a small-package copy shares all inputs.
`timescale 1ns/1ns
`default_nettype none
`include "ais_defines.vh"
module ais_input_select_tb;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic sample_req = 1'b0;
    logic [15:0] rdata, rdata_s;
    logic [23:0] pins, pins_s;
    logic half, full, core, sixth, neg1, negv, flt, on6, on2, on1, tick;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;

    always #5 sys_clk = ~sys_clk;

    ais_input_select i_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(rdata), .sample_req(sample_req), .ain_pos_sel(pins),
        .half_ref_sel(half), .full_ref_sel(full), .core_supply_sel(core),
        .sixth_ref_sel(sixth), .neg_ain1_sel(neg1), .neg_vref_sel(negv),
        .inputs_floating(flt), .sixth_ref_on(on6), .half_ref_on(on2),
        .full_ref_on(on1), .conv_clk_tick(tick));
    ais_input_select #(.SMALL_PACKAGE(1)) i_dut_small (
        .sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(rdata_s), .sample_req(sample_req), .ain_pos_sel(pins_s),
        .half_ref_sel(), .full_ref_sel(), .core_supply_sel(),
        .sixth_ref_sel(), .neg_ain1_sel(), .neg_vref_sel(),
        .inputs_floating(), .sixth_ref_on(), .half_ref_on(),
        .full_ref_on(), .conv_clk_tick());

    // ------------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------------
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [2:0] a, input logic [15:0] e, input logic [15:0] es);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        chk("rdata", rdata, e);
        chk("rdata_small", rdata_s, es);
    endtask
    // Expected source vector {float, sixth, core, full, half, pins}
    function automatic logic [28:0] src(input logic [4:0] c, input bit sm);
        src = 29'h0;
        if (c <= `AIS_CODE_LAST_PIN && !(sm && c > `AIS_CODE_LAST_SMALL_PIN))
            src[c] = 1'b1;
        else if (c >= `AIS_CODE_HALF_REF && c <= `AIS_CODE_SIXTH_REF)
            src[c] = 1'b1;
        else if (c == `AIS_CODE_NONE)
            src[28] = 1'b1;
    endfunction
    // Switches settle two edges after the request edge
    task smp(input logic [28:0] e, input logic [28:0] es, input logic n);
        @(posedge sys_clk);
        sample_req <= 1'b1;
        @(posedge sys_clk);
        sample_req <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk("source", {flt, sixth, core, full, half, pins}, e);
        chk("source_small", pins_s, es[23:0]);
        // No-channel code floats the negative input as well
        chk("negative", {neg1, negv},
            e[28] ? 2'b00 : {n, ~n});
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_regs;
        for (int a = 0; a < 4; a++) rd(a[2:0], 16'h0000, 16'h0000);
        for (int a = 0; a < 4; a++) wr(a[2:0], 16'hFFFF);
        rd(`AIS_OFS_INPUT_SELECT, 16'h9F9F, 16'h9F9F);
        rd(`AIS_OFS_BANDGAP_CFG, 16'h0007, 16'h0007);
        rd(`AIS_OFS_SCAN_LOW, 16'hFFFF, 16'hFFFF);
        rd(`AIS_OFS_SCAN_HIGH, 16'h0FFF, 16'h0F00);
        rd(3'h7, 16'h0000, 16'h0000);
        chk("taps", {on6, on2, on1}, 3'h7);
        wr(`AIS_OFS_BANDGAP_CFG, 16'h0005);
        repeat (2) @(posedge sys_clk);
        #1;
        chk("taps", {on6, on2, on1}, 3'h5);
    endtask
    // Every legal code through A alone, then A, B, A in alternate mode
    task t_codes;
        logic [4:0] c;
        for (int i = 0; i < 32; i++) begin
            c = i[4:0];
            if (c < 5'h1C || c == `AIS_CODE_NONE) begin
                wr(`AIS_OFS_INPUT_SELECT, {3'h0, c, 3'h4, c});
                wr(`AIS_OFS_SEQ_CTRL, 16'h0000);
                smp(src(c, 0), src(c, 1), 1'b1);
                wr(`AIS_OFS_SEQ_CTRL, 16'h0001);
                smp(src(c, 0), src(c, 1), 1'b1);
                smp(src(c, 0), src(c, 1), 1'b0);
                smp(src(c, 0), src(c, 1), 1'b1);
            end
        end
    endtask
    task t_scan;
        wr(`AIS_OFS_INPUT_SELECT, 16'h0005);
        wr(`AIS_OFS_SCAN_LOW, 16'h8009);
        wr(`AIS_OFS_SCAN_HIGH, 16'h0100);
        wr(`AIS_OFS_SEQ_CTRL, 16'h0400);
        smp(src(5'h00, 0), src(5'h00, 1), 1'b0);
        smp(src(5'h03, 0), src(5'h03, 1), 1'b0);
        smp(src(5'h0F, 0), src(5'h0F, 1), 1'b0);
        smp(src(5'h18, 0), src(5'h18, 1), 1'b0);
        smp(src(5'h00, 0), src(5'h00, 1), 1'b0);
        wr(`AIS_OFS_SEQ_CTRL, 16'h0000);
        smp(src(5'h05, 0), src(5'h05, 1), 1'b0);
    endtask
    task t_div;
        int n;
        wr(`AIS_OFS_CLK_DIV, 16'h0003);
        repeat (520) @(posedge sys_clk);
        #1;
        n = 0;
        while (tick !== 1'b1 && n < 300) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (tick !== 1'b1 && n < 300);
        chk("tick_period", n, 4);
    endtask

    task end_of_test;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Ceiling well above the roughly 1250 cycles the scenarios need
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 8000) begin
            error_cnt++;
            end_of_test;
        end
    end

    initial begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_regs;
        t_codes;
        t_scan;
        t_div;
        end_of_test;
    end
endmodule
`default_nettype wire
